//--- src/ssbc_pkg.sv
// constants, states and state record of the sound IF bus control and synthesizer
package ssbc_pkg;
  // ==================================================
  // bus addressing
  localparam logic [7:0] ADDR_GROUNDED = 8'h44;
  localparam logic [7:0] ADDR_ALT = 8'h46;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;
  // ==================================================
  // field positions inside received bytes
  localparam int CLASS_BIT = 7;
  localparam int BOOST_BIT = 6;
  localparam int ROUTE_LSB = 3;
  localparam int LEFT_LSB = 4;
  localparam int RIGHT_LSB = 1;
  localparam int DIV_FIELD_LSB = 0;
  localparam int DIV_FIELD_W = 6;
  // ==================================================
  // values after reset
  localparam logic [11:0] DIV_RATIO_RST = 12'h400;
  localparam logic [2:0] ROUTE_RST = 3'h7;
  localparam logic [2:0] VOL_RST = 3'h0;
  localparam logic [2:0] IF_EN_RST = 3'h0;
  // ==================================================
  // reference divider: crystal edges per reference period and half period
  localparam logic [7:0] REF_DIV = 8'hc8;
  localparam logic [7:0] REF_HALF = 8'h64;
  // ==================================================
  // receiver states
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_RECV = 4'h2,
    S_ACK = 4'h4,
    S_SKIP = 4'h8
  } ssbc_state_t;
  // ==================================================
  // whole state of the block
  typedef struct packed {
    logic sclMeta;
    logic sclSync;
    logic sclLast;
    logic sdaMeta;
    logic sdaSync;
    logic sdaLast;
    logic selMeta;
    logic selSync;
    logic xtMeta;
    logic xtSync;
    logic xtLast;
    logic vcMeta;
    logic vcSync;
    logic vcLast;
    ssbc_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic isAddr;
    logic grpDiv;
    logic [1:0] grpIdx;
    logic sdaLow;
    logic [5:0] divUpper;
    logic [11:0] divRatio;
    logic pumpBoost;
    logic [2:0] routeSel;
    logic [2:0] ifEn;
    logic [2:0] volLeft;
    logic [2:0] volRight;
    logic [2:0] prevolLeft;
    logic [2:0] prevolRight;
    logic [7:0] refCnt;
    logic [11:0] vcoCnt;
    logic pumpSrc;
    logic pumpSnk;
  } ssbc_regs_t;
endpackage

//--- src/ssbc_top.sv
// two-wire write-only control slave with synthesizer dividers and phase detector
//
// Overview of operation
// - idle bus: both lines high, data released
// - data falling while clock high starts telegram
// - data sampled on rising clock edge
// - data rising while clock high stops telegram
// - ninth clock: device pulls data low
// - first byte is address, direction bit low
// - select input picks address 44 or 46
// - top bit classifies divider or control bytes
// - vco divided by twelve-bit ratio 1-4095 (0 gives 4096)
// - reference is crystal divided by 200
// - vco edge first: source pulses for difference
// - reference edge first: sink pulses for difference
// - in phase: neither source nor sink
// - boost bit selects one or five current
// - reset keeps data line released
// - works with clock up to 400 kHz
// - routing bits select sources and audio mode
// - volume and pre-volume fields per channel
`timescale 1ns/100ps
`default_nettype none

module ssbc_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectBit,
  input wire logic xtalIn,
  input wire logic vcoIn,
  output logic pumpSource,
  output logic pumpSink,
  output logic pumpBoost,
  output logic [2:0] routeSel,
  output logic narrowIfA,
  output logic narrowIfB,
  output logic wideIf,
  output logic [2:0] volLeft,
  output logic [2:0] volRight,
  output logic [2:0] prevolLeft,
  output logic [2:0] prevolRight,
  output logic [11:0] divRatio
);
  import ssbc_pkg::*;

  // ==================================================
  // helpers
  // address byte that this device answers to
  function automatic logic [7:0] addrFor(input logic sel);
    addrFor = sel ? ADDR_ALT : ADDR_GROUNDED;
  endfunction
  // three-bit field of a received byte
  function automatic logic [2:0] field3(input logic [7:0] b, input int lsb);
    field3 = b[lsb +: 3];
  endfunction
  // routing code to source enables: {wide, narrow b, narrow a}
  function automatic logic [2:0] routeToIf(input logic [2:0] r);
    unique case (r)
      3'h0: routeToIf = 3'h3;
      3'h1: routeToIf = 3'h2;
      3'h2: routeToIf = 3'h1;
      3'h3, 3'h4, 3'h5: routeToIf = 3'h4;
      default: routeToIf = 3'h0;
    endcase
  endfunction

  // ==================================================
  // state record
  ssbc_regs_t st_ff;
  ssbc_regs_t nxt_st;

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic xtRise;
  logic vcRise;
  logic refFall;
  logic vcoFall;
  logic addrMatch;
  logic byteDone;
  logic ackEnd;
  logic divLatchLower;
  logic [11:0] vcoHalf;

  // edge and condition detection on synchronised lines
  assign sclRise = st_ff.sclSync & ~st_ff.sclLast;
  assign sclFall = ~st_ff.sclSync & st_ff.sclLast;
  assign startCond = st_ff.sclSync & st_ff.sclLast & st_ff.sdaLast & ~st_ff.sdaSync;
  assign stopCond = st_ff.sclSync & st_ff.sclLast & ~st_ff.sdaLast & st_ff.sdaSync;
  assign addrMatch = (st_ff.shiftReg == addrFor(st_ff.selSync));
  assign byteDone = (st_ff.state == S_RECV) && (st_ff.bitCnt == BIT_COUNT_FULL) && sclFall;
  assign ackEnd = (st_ff.state == S_ACK) && sclFall && !startCond && !stopCond;
  assign divLatchLower = ackEnd && !st_ff.isAddr && st_ff.grpIdx == 2'h1 && st_ff.grpDiv;
  // synthesizer edge events
  assign xtRise = st_ff.xtSync & ~st_ff.xtLast;
  assign vcRise = st_ff.vcSync & ~st_ff.vcLast;
  assign vcoHalf = {1'b0, st_ff.divRatio[11:1]};
  assign refFall = xtRise && (st_ff.refCnt == REF_HALF - 8'h01);
  assign vcoFall = vcRise && (st_ff.vcoCnt == vcoHalf - 12'h001);
  // ==================================================
  // next-state logic
  always_comb begin
    nxt_st = st_ff;
    // two-flop synchronisers; plenty of samples per bit at the top bus rate
    nxt_st.sclMeta = sclIn;
    nxt_st.sclSync = st_ff.sclMeta;
    nxt_st.sclLast = st_ff.sclSync;
    nxt_st.sdaMeta = sdaIn;
    nxt_st.sdaSync = st_ff.sdaMeta;
    nxt_st.sdaLast = st_ff.sdaSync;
    nxt_st.selMeta = addrSelectBit;
    nxt_st.selSync = st_ff.selMeta;
    nxt_st.xtMeta = xtalIn;
    nxt_st.xtSync = st_ff.xtMeta;
    nxt_st.xtLast = st_ff.xtSync;
    nxt_st.vcMeta = vcoIn;
    nxt_st.vcSync = st_ff.vcMeta;
    nxt_st.vcLast = st_ff.vcSync;

    // telegram receiver; start and stop override everything
    if (startCond) begin
      nxt_st.state = S_RECV;
      nxt_st.bitCnt = 4'h0;
      nxt_st.isAddr = 1'b1;
      nxt_st.grpIdx = 2'h0;
      nxt_st.sdaLow = 1'b0;
    end else if (stopCond) begin
      nxt_st.state = S_IDLE;
      nxt_st.sdaLow = 1'b0;
    end else begin
      unique case (st_ff.state)
        S_IDLE: begin
          nxt_st.sdaLow = 1'b0;
        end
        S_RECV: begin
          if (sclRise && st_ff.bitCnt != BIT_COUNT_FULL) begin
            nxt_st.shiftReg = {st_ff.shiftReg[6:0], st_ff.sdaSync};
            nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
          end else if (byteDone) begin
            if (st_ff.isAddr && !addrMatch) begin
              nxt_st.state = S_SKIP;
            end else begin
              nxt_st.state = S_ACK;
              nxt_st.sdaLow = 1'b1;
            end
          end
        end
        S_ACK: begin
          if (sclFall) begin
            nxt_st.sdaLow = 1'b0;
            nxt_st.state = S_RECV;
            nxt_st.bitCnt = 4'h0;
            nxt_st.isAddr = 1'b0;
            if (!st_ff.isAddr) begin
              // latch the acknowledged byte, skipping don't-care bits
              if (st_ff.grpIdx == 2'h0) begin
                nxt_st.grpDiv = !st_ff.shiftReg[CLASS_BIT];
              end
              if ((st_ff.grpIdx == 2'h0) ? !st_ff.shiftReg[CLASS_BIT] : st_ff.grpDiv) begin
                if (st_ff.grpIdx == 2'h0) begin
                  nxt_st.divUpper = st_ff.shiftReg[DIV_FIELD_LSB +: DIV_FIELD_W];
                  nxt_st.grpIdx = 2'h1;
                end else begin
                  // whole ratio swapped in at once
                  nxt_st.divRatio = {st_ff.divUpper,
                    st_ff.shiftReg[DIV_FIELD_LSB +: DIV_FIELD_W]};
                  nxt_st.grpIdx = 2'h0;
                end
              end else begin
                unique case (st_ff.grpIdx)
                  2'h0: begin
                    nxt_st.pumpBoost = st_ff.shiftReg[BOOST_BIT];
                    nxt_st.routeSel = field3(st_ff.shiftReg, ROUTE_LSB);
                    nxt_st.ifEn = routeToIf(field3(st_ff.shiftReg, ROUTE_LSB));
                    nxt_st.grpIdx = 2'h1;
                  end
                  2'h1: begin
                    nxt_st.volLeft = field3(st_ff.shiftReg, LEFT_LSB);
                    nxt_st.volRight = field3(st_ff.shiftReg, RIGHT_LSB);
                    nxt_st.grpIdx = 2'h2;
                  end
                  default: begin
                    nxt_st.prevolLeft = field3(st_ff.shiftReg, LEFT_LSB);
                    nxt_st.prevolRight = field3(st_ff.shiftReg, RIGHT_LSB);
                    nxt_st.grpIdx = 2'h0;
                  end
                endcase
              end
            end
          end
        end
        S_SKIP: begin
          nxt_st.sdaLow = 1'b0;
        end
        default: begin
          nxt_st.state = S_IDLE;
          nxt_st.sdaLow = 1'b0;
        end
      endcase
    end
    // reference divider from the crystal
    if (xtRise) begin
      nxt_st.refCnt = (st_ff.refCnt >= REF_DIV - 8'h01) ? 8'h00 : st_ff.refCnt + 8'h01;
    end
    // programmable vco divider
    if (vcRise) begin
      nxt_st.vcoCnt = (st_ff.vcoCnt >= st_ff.divRatio - 12'h001) ? 12'h000 :
        st_ff.vcoCnt + 12'h001;
    end
    // three-state phase detector on falling edges of the divided signals
    if (vcoFall && !refFall) begin
      if (st_ff.pumpSnk) begin
        nxt_st.pumpSnk = 1'b0;
      end else begin
        nxt_st.pumpSrc = 1'b1;
      end
    end else if (refFall && !vcoFall) begin
      if (st_ff.pumpSrc) begin
        nxt_st.pumpSrc = 1'b0;
      end else begin
        nxt_st.pumpSnk = 1'b1;
      end
    end else if (refFall && vcoFall) begin
      nxt_st.pumpSrc = 1'b0;
      nxt_st.pumpSnk = 1'b0;
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.sclMeta <= 1'b1;
      st_ff.sclSync <= 1'b1;
      st_ff.sclLast <= 1'b1;
      st_ff.sdaMeta <= 1'b1;
      st_ff.sdaSync <= 1'b1;
      st_ff.sdaLast <= 1'b1;
      st_ff.state <= S_IDLE;
      st_ff.divRatio <= DIV_RATIO_RST;
      st_ff.routeSel <= ROUTE_RST;
      st_ff.ifEn <= IF_EN_RST;
      st_ff.volLeft <= VOL_RST;
      st_ff.volRight <= VOL_RST;
      st_ff.prevolLeft <= VOL_RST;
      st_ff.prevolRight <= VOL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==================================================
  // outputs
  // open-drain data line: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOe = st_ff.sdaLow;
  assign pumpSource = st_ff.pumpSrc;
  assign pumpSink = st_ff.pumpSnk;
  assign pumpBoost = st_ff.pumpBoost;
  assign routeSel = st_ff.routeSel;
  assign narrowIfA = st_ff.ifEn[0];
  assign narrowIfB = st_ff.ifEn[1];
  assign wideIf = st_ff.ifEn[2];
  assign volLeft = st_ff.volLeft;
  assign volRight = st_ff.volRight;
  assign prevolLeft = st_ff.prevolLeft;
  assign prevolRight = st_ff.prevolRight;
  assign divRatio = st_ff.divRatio;

  // ==================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_idle_released;
    (st_ff.state == S_IDLE) || (st_ff.state == S_SKIP) |-> !sdaOe;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("data pulled while idle");
  property p_start_seen;
    startCond |=> (st_ff.state == S_RECV) && (st_ff.bitCnt == 4'h0) && st_ff.isAddr;
  endproperty
  a_start_seen: assert property (p_start_seen) else $error("start not taken");
  property p_sample_rise;
    (st_ff.state == S_RECV) && sclRise && !startCond && !stopCond &&
      (st_ff.bitCnt != BIT_COUNT_FULL) |=> st_ff.shiftReg[0] == $past(st_ff.sdaSync);
  endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("bit not sampled");
  property p_stop_idle;
    stopCond |=> (st_ff.state == S_IDLE) && !sdaOe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");
  property p_ack_pull;
    byteDone && !startCond && !stopCond && !st_ff.isAddr |=> sdaOe;
  endproperty
  a_ack_pull: assert property (p_ack_pull) else $error("data byte not acknowledged");
  property p_addr_filter;
    byteDone && !startCond && !stopCond && st_ff.isAddr |=> sdaOe == $past(addrMatch);
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("wrong address answer");
  property p_ratio_atomic;
    !$stable(st_ff.divRatio) |-> $past(divLatchLower);
  endproperty
  a_ratio_atomic: assert property (p_ratio_atomic) else $error("ratio changed early");
  property p_ref_range;
    st_ff.refCnt < REF_DIV;
  endproperty
  a_ref_range: assert property (p_ref_range) else $error("reference count out of range");
  property p_source_ends;
    pumpSource && refFall && !vcoFall |=> !pumpSource && !pumpSink;
  endproperty
  a_source_ends: assert property (p_source_ends) else $error("source not ended");
  // a vco edge may follow at once and end the sink, so only its start is pinned
  property p_sink_starts;
    refFall && !vcoFall && !pumpSource |=> pumpSink && !pumpSource;
  endproperty
  a_sink_starts: assert property (p_sink_starts) else $error("sink not started");
  property p_never_both;
    !(pumpSource && pumpSink);
  endproperty
  a_never_both: assert property (p_never_both) else $error("source and sink together");
  property p_in_phase;
    refFall && vcoFall |=> !pumpSource && !pumpSink;
  endproperty
  a_in_phase: assert property (p_in_phase) else $error("pump active on in-phase edges");
  c_addr_ack: cover property (byteDone && st_ff.isAddr && addrMatch);
  c_ratio_applied: cover property (divLatchLower);
  c_prevol_latched: cover property (ackEnd && !st_ff.grpDiv && st_ff.grpIdx == 2'h2);
  c_source_pulse: cover property (!pumpSource ##1 pumpSource);
endmodule

`default_nettype wire

//--- bench/ssbc_host.sv
// host model: two-wire bus master that sends write telegrams to the device
`timescale 1ns/100ps
`default_nettype none

module ssbc_host #(
  parameter int Q = 80
) (
  input wire logic core_clk,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sdaLowOut
);
  // ==================================================
  // idle: both lines released, pull-up holds them high
  initial begin
    sclOut = 1'b1;
    sdaLowOut = 1'b0;
  end

  // ==================================================
  // timing helpers; a clock phase of 2*Q cycles keeps the bus at 400 kHz or below
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // data falls while clock stays high
  task automatic bus_start();
    wait_clk(1);
    sdaLowOut <= 1'b1;
    wait_clk(2 * Q);
    sclOut <= 1'b0;
  endtask

  // eight bits msb first, then a released ninth bit sampled late in its high phase
  task automatic send_byte(input logic [7:0] b, output logic acked);
    for (int i = 7; i >= 0; i--) begin
      wait_clk(Q);
      sdaLowOut <= !b[i];
      wait_clk(Q);
      sclOut <= 1'b1;
      wait_clk(2 * Q);
      sclOut <= 1'b0;
    end
    wait_clk(Q);
    sdaLowOut <= 1'b0;
    wait_clk(Q);
    sclOut <= 1'b1;
    wait_clk(2 * Q - 1);
    acked = !sdaIn;
    wait_clk(1);
    sclOut <= 1'b0;
    wait_clk(8);
  endtask

  // data rises while clock high, then the bus rests idle; telegrams never mix groups
  task automatic bus_stop();
    wait_clk(Q);
    sdaLowOut <= 1'b1;
    wait_clk(Q);
    sclOut <= 1'b1;
    wait_clk(Q);
    sdaLowOut <= 1'b0;
    wait_clk(2 * Q);
  endtask
endmodule

`default_nettype wire

//--- bench/ssbc_top_test.sv
// self-checking bench: bus telegrams, latched fields and synthesizer pump pulses
`timescale 1ns/100ps
`default_nettype none

module ssbc_top_test;
  import ssbc_pkg::*;
  // ==================================================
  // stimulus and observed signals
  localparam logic [11:0] RATIO = 12'h4c2;
  localparam logic [2:0] IF_TAB [8] = '{3'h6, 3'h2, 3'h4, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic addrSelectBit = 1'b0;
  logic xtalIn = 1'b0;
  logic vcoIn = 1'b0;
  logic sclLine, hostLow, sdaLine, sdaOut, sdaOe, ack;
  logic pumpSource, pumpSink, pumpBoost, narrowIfA, narrowIfB, wideIf;
  logic [2:0] routeSel, volLeft, volRight, prevolLeft, prevolRight;
  logic [11:0] divRatio;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;

  // open-drain data wire with pull-up
  assign sdaLine = !(hostLow || (sdaOe && !sdaOut));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  ssbc_host host (
    .core_clk(core_clk),
    .sdaIn(sdaLine),
    .sclOut(sclLine),
    .sdaLowOut(hostLow)
  );

  ssbc_top uut (
    .core_clk(core_clk),
    .rst(rst),
    .sclIn(sclLine),
    .sdaIn(sdaLine),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .addrSelectBit(addrSelectBit),
    .xtalIn(xtalIn),
    .vcoIn(vcoIn),
    .pumpSource(pumpSource),
    .pumpSink(pumpSink),
    .pumpBoost(pumpBoost),
    .routeSel(routeSel),
    .narrowIfA(narrowIfA),
    .narrowIfB(narrowIfB),
    .wideIf(wideIf),
    .volLeft(volLeft),
    .volRight(volRight),
    .prevolLeft(prevolLeft),
    .prevolRight(prevolRight),
    .divRatio(divRatio)
  );

  // ==================================================
  // compare, verdict and bus helpers
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic expAck);
    host.send_byte(b, ack);
    chk("ack", 12'(expAck), 12'(ack));
  endtask

  // link pulses of 32 ns, one every 64 ns, on crystal (sel 0) or vco (sel 1)
  task automatic pulse(input logic sel, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (sel) vcoIn <= 1'b1;
      else xtalIn <= 1'b1;
      repeat (4) @(posedge core_clk);
      if (sel) vcoIn <= 1'b0;
      else xtalIn <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 105000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ==================================================
  // main sequence
  initial begin
    repeat (15) @(posedge core_clk);
    chk("oe in reset", 12'h0, 12'(sdaOe));
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("idle wire", 12'h1, 12'(sdaLine));
    chk("route reset", 12'h7, 12'(routeSel));
    chk("ratio reset", 12'h400, divRatio);
    // foreign address and read direction are refused
    host.bus_start();
    put(8'h48, 1'b0);
    host.bus_stop();
    host.bus_start();
    put(ADDR_GROUNDED | 8'h01, 1'b0);
    host.bus_stop();
    // divider pair applied only after its second byte
    host.bus_start();
    put(ADDR_GROUNDED, 1'b1);
    put({2'h0, RATIO[11:6]}, 1'b1);
    chk("ratio half", 12'h400, divRatio);
    put({2'h0, RATIO[5:0]}, 1'b1);
    chk("ratio", RATIO, divRatio);
    host.bus_stop();
    // control group with don't-care bits set
    host.bus_start();
    put(ADDR_GROUNDED, 1'b1);
    put(8'hef, 1'b1);
    chk("boost", 12'h1, 12'(pumpBoost));
    chk("route", 12'h5, 12'(routeSel));
    put(8'hbd, 1'b1);
    chk("vol", 12'h36, 12'({volLeft, 1'b0, volRight}));
    put(8'hd5, 1'b1);
    chk("prevol", 12'h52, 12'({prevolLeft, 1'b0, prevolRight}));
    host.bus_stop();
    // alternate address: old one refused, every routing code decoded
    addrSelectBit <= 1'b1;
    host.bus_start();
    put(ADDR_GROUNDED, 1'b0);
    host.bus_stop();
    for (int c = 0; c < 8; c++) begin
      host.bus_start();
      put(ADDR_ALT, 1'b1);
      put({1'b1, 1'(c), 3'(c), 3'h0}, 1'b1);
      chk("route", 12'(c), 12'(routeSel));
      chk("boost", 12'(c % 2), 12'(pumpBoost));
      chk("sources", 12'(IF_TAB[c]), 12'({narrowIfA, narrowIfB, wideIf}));
      host.bus_stop();
    end
    // synthesizer: reference falls after 100 then 200 crystal edges, vco at half and full ratio
    pulse(1'b0, 99);
    chk("pump", 12'h0, 12'({pumpSource, pumpSink}));
    pulse(1'b0, 1);
    chk("pump", 12'h1, 12'({pumpSource, pumpSink}));
    pulse(1'b1, 608);
    chk("pump", 12'h1, 12'({pumpSource, pumpSink}));
    pulse(1'b1, 1);
    chk("pump", 12'h0, 12'({pumpSource, pumpSink}));
    pulse(1'b1, 1217);
    chk("pump", 12'h0, 12'({pumpSource, pumpSink}));
    pulse(1'b1, 1);
    chk("pump", 12'h2, 12'({pumpSource, pumpSink}));
    pulse(1'b0, 199);
    chk("pump", 12'h2, 12'({pumpSource, pumpSink}));
    pulse(1'b0, 1);
    chk("pump", 12'h0, 12'({pumpSource, pumpSink}));
    report_and_stop();
  end
endmodule

`default_nettype wire
